// File: dcx_defs.vh
// Constants for the disk command and transfer controller.
// Assumes a 100 MHz system clock and 32-bit APB register access.
`ifndef DCX_DEFS_VH
`define DCX_DEFS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DCX_OFF_CTRL_STAT 12'h000
`define DCX_OFF_CMD_DRIVE 12'h004
`define DCX_OFF_DRV_STAT 12'h008
`define DCX_OFF_CYLINDER 12'h00c
`define DCX_OFF_SURF_SECT 12'h010
`define DCX_OFF_ADDR_START 12'h014
`define DCX_OFF_CONFIG 12'h018
// ----------------------------------------
// Controller status bits (word bit 15 is accumulator bit 0)
// ----------------------------------------
`define DCX_ST_PEND 15
`define DCX_ST_BUSY 14
`define DCX_ST_XDONE 13
`define DCX_ST_DDONE 12
`define DCX_ST_TMO 11
`define DCX_ST_CYLERR 10
`define DCX_ST_SRFERR 9
`define DCX_ST_BADSEC 8
// ----------------------------------------
// Drive status bits
// ----------------------------------------
`define DCX_DS_READY 15
`define DCX_DS_RSVD 14
`define DCX_DS_FAULT 13
`define DCX_DS_BUSY 12
`define DCX_DS_WPROT 11
// ----------------------------------------
// Accumulator fields (bit n of accumulator is word bit 15-n)
// ----------------------------------------
`define DCX_DRV_HI 6
`define DCX_DRV_LO 5
`define DCX_CMD_HI 10
`define DCX_CMD_LO 7
`define DCX_SRF_HI 14
`define DCX_SRF_LO 10
`define DCX_SRF4_HI 13
`define DCX_SEC_HI 9
`define DCX_SEC_LO 5
`define DCX_CNT_HI 4
`define DCX_CNT_LO 0
// ----------------------------------------
// Transfer command codes
// ----------------------------------------
`define DCX_CODE_READ 4'h0
`define DCX_CODE_WRITE 4'he
`define DCX_CODE_VERIFY 4'hc
// ----------------------------------------
// Timing
// ----------------------------------------
`define DCX_TMO_MS 1000
`define DCX_CLK_KHZ 100000
`define DCX_TMO_CYCLES (`DCX_TMO_MS * `DCX_CLK_KHZ)
`define DCX_WORDS_PER_SECTOR 256
`endif

// File: dcx_sync.v
// Two-flop synchroniser, one per bit.
// Assumes asynchronous level inputs; only the second stage is read outside.
`timescale 1ns/1ps
`default_nettype none
module dcx_sync #(
    parameter W = 1
) (
    input wire clk_sys,
    input wire srst,
    input wire [W-1:0] asyncIn,
    output wire [W-1:0] syncOut
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : gBit
            reg stage1_q;
            reg stage2_q;
            always @(posedge clk_sys) begin
                if (srst) begin
                    stage1_q <= 1'b0;
                    stage2_q <= 1'b0;
                end else begin
                    stage1_q <= asyncIn[i];
                    stage2_q <= stage1_q;
                end
            end
            assign syncOut[i] = stage2_q;
        end
    endgenerate
endmodule
`default_nettype wire

// File: dcx_timer.v
// Transfer timeout timer: restarts on start, stops on stop, pulses on expiry.
// Assumes start and stop are single-cycle pulses on clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "dcx_defs.vh"
module dcx_timer #(
    parameter CYCLES = `DCX_TMO_CYCLES
) (
    input wire clk_sys,
    input wire srst,
    input wire start,
    input wire stop,
    output reg expired
);
    reg [31:0] count_q;
    reg run_q;
    always @(posedge clk_sys) begin
        if (srst) begin
            count_q <= 32'h00000000;
            run_q <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (start) begin
                count_q <= 32'h00000000;
                run_q <= 1'b1;
            end else if (stop) begin
                run_q <= 1'b0;
            end else if (run_q) begin
                if (count_q == CYCLES - 1) begin
                    run_q <= 1'b0;
                    expired <= 1'b1;
                end else begin
                    count_q <= count_q + 32'h00000001;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: dcx_ctrl.v
// Disk command and transfer controller: APB registers, drive command path,
// sector search and DMA transfer sequencing with a transfer timeout.
// Assumes drive status pins are asynchronous; header and DMA signals are on clk_sys.
// Functional notes
// [R1] Pending flag in status bit 0; command writes ignored while it is set.
// [R2] Command write loads accumulator bits 9-10 as drive number.
// [R3] Command write loads accumulator bits 5-8 as four-bit command code.
// [R4] Recalibrate, seek, trespass and release all use the same issue sequence.
// [R5] Codes 0000 read, 1110 write, 1100 verify start data transfers.
// [R6] Drive status read shows ready, reserved, fault and busy of selected drive.
// [R7] Cylinder load on unready, busy or reserved drive: set drive-done, clear pending.
// [R8] Cylinder load latches cylinder, sets pending, sends command; clears when taken.
// [R9] Drive command completion sets drive-done; interrupts only while not busy.
// [R10] Transfer command accepted while a seek is still running.
// [R11] Processor does not start a transfer while busy is set.
// [R12] Surface from bits 1-5, or bits 2-5 in the multifunction variant.
// [R13] Surface-sector write loads bits 6-10 as starting sector.
// [R14] Surface-sector write loads bits 11-15 into five-bit sector count.
// [R15] Address-and-start loads DMA address, sets busy, clears done, starts timeout.
// [R16] Find sector, transfer sectors until sector count overflows, then stop.
// [R17] Transfer end clears busy, sets done, raises interrupt.
// [R18] Transfer not finished within one second is aborted and ended.
// [R19] Processor checks ready, no fault, not write-protected before writing.
// [R20] Header CRC error retries next header; cylinder or surface mismatch stops.
// [R21] On address match, bad sector stops; alternate flag redirects to alternate.
// [R22] Each sector done advances sector address and increments sector count.
// [R23] DMA address advances by one per data word moved.
`timescale 1ns/1ps
`default_nettype none
`include "dcx_defs.vh"
module dcx_ctrl #(
    parameter CYL_W = 10,
    parameter ADDR_W = 16,
    parameter WORDS = `DCX_WORDS_PER_SECTOR,
    parameter TMO_CYCLES = `DCX_TMO_CYCLES
) (
    input wire clk_sys,
    input wire srst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    input wire drvReadyPin,
    input wire drvReservedPin,
    input wire drvFaultPin,
    input wire drvBusyPin,
    input wire drvWriteProtPin,
    input wire drvTakenPin,
    input wire drvDonePin,
    output reg drvCmdValid,
    output reg [1:0] drvSel,
    output reg [3:0] drvCmd,
    output reg [CYL_W-1:0] drvCyl,
    input wire hdrValid,
    input wire [CYL_W-1:0] hdrCyl,
    input wire [4:0] hdrSurf,
    input wire [4:0] hdrSector,
    input wire hdrCrcErr,
    input wire hdrBad,
    input wire hdrAlt,
    input wire [4:0] hdrAltSector,
    output reg xferActive,
    output reg [3:0] xferCmd,
    output reg [4:0] xferSurf,
    output reg [4:0] xferSector,
    output reg dmaReq,
    output reg dmaToMem,
    output reg [ADDR_W-1:0] dmaAddr,
    input wire dmaAck,
    output wire irq
);
    // ----------------------------------------
    // Pin synchronisation and edge detection
    // ----------------------------------------
    wire [6:0] pinSync;
    reg takenDly_q;
    reg doneDly_q;
    dcx_sync #(.W(7)) uSync (
        .clk_sys(clk_sys),
        .srst(srst),
        .asyncIn({drvDonePin, drvTakenPin, drvWriteProtPin, drvBusyPin, drvFaultPin,
                  drvReservedPin, drvReadyPin}),
        .syncOut(pinSync)
    );
    wire dReady = pinSync[0];
    wire dRsvd = pinSync[1];
    wire dFault = pinSync[2];
    wire dBusy = pinSync[3];
    wire dWprot = pinSync[4];
    wire takenRise = pinSync[5] & ~takenDly_q;
    wire doneRise = pinSync[6] & ~doneDly_q;
    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    wire apbWr = psel & penable & pwrite;
    wire apbRd = psel & penable & ~pwrite;
    wire selStat = (paddr == `DCX_OFF_CTRL_STAT);
    wire selCmd = (paddr == `DCX_OFF_CMD_DRIVE);
    wire selDst = (paddr == `DCX_OFF_DRV_STAT);
    wire selCyl = (paddr == `DCX_OFF_CYLINDER);
    wire selSsc = (paddr == `DCX_OFF_SURF_SECT);
    wire selAdr = (paddr == `DCX_OFF_ADDR_START);
    wire selCfg = (paddr == `DCX_OFF_CONFIG);
    wire mapped = selStat | selCmd | selDst | selCyl | selSsc | selAdr | selCfg;
    assign pready = 1'b1;
    // ----------------------------------------
    // Registers and flags
    // ----------------------------------------
    reg pend_q;
    reg busy_q;
    reg xDone_q;
    reg dDone_q;
    reg tmoErr_q;
    reg cylErr_q;
    reg srfErr_q;
    reg badSec_q;
    reg multiFn_q;
    reg [4:0] secCnt_q;
    reg [8:0] wordCnt_q;
    reg [1:0] state_q;
    localparam ST_IDLE = 2'b00;
    localparam ST_SEARCH = 2'b01;
    localparam ST_XFER = 2'b10;
    wire isXferCode = (xferCmd == `DCX_CODE_READ) | (xferCmd == `DCX_CODE_WRITE) |
                      (xferCmd == `DCX_CODE_VERIFY); // [R5]
    wire cylWr = apbWr & selCyl & ~pend_q;
    wire startWr = apbWr & selAdr & ~busy_q & isXferCode; // [R10] [R11]
    wire tmoExpired;
    reg xferEnd;
    reg endCyl;
    reg endSrf;
    reg endBad;
    wire wordLast = dmaReq & dmaAck & (wordCnt_q == WORDS - 1);
    wire cntOvf = (secCnt_q == 5'h1f);
    // ----------------------------------------
    // Sector search and transfer decisions
    // ----------------------------------------
    always @* begin
        xferEnd = 1'b0;
        endCyl = 1'b0;
        endSrf = 1'b0;
        endBad = 1'b0;
        if (state_q != ST_IDLE && tmoExpired) begin
            xferEnd = 1'b1; // [R18]
        end else if (state_q == ST_SEARCH && hdrValid && !hdrCrcErr) begin
            if (hdrCyl != drvCyl) begin
                endCyl = 1'b1; // [R20]
            end else if (hdrSurf != xferSurf) begin
                endSrf = 1'b1; // [R20]
            end else if (hdrSector == xferSector && hdrBad) begin
                endBad = 1'b1; // [R21]
            end
            xferEnd = endCyl | endSrf | endBad;
        end else if (state_q == ST_XFER && wordLast && cntOvf) begin
            xferEnd = 1'b1; // [R16]
        end
    end
    dcx_timer #(.CYCLES(TMO_CYCLES)) uTimer (
        .clk_sys(clk_sys),
        .srst(srst),
        .start(startWr), // [R15]
        .stop(xferEnd),
        .expired(tmoExpired)
    );
    // ----------------------------------------
    // Drive command path
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (srst) begin
            takenDly_q <= 1'b0;
            doneDly_q <= 1'b0;
            pend_q <= 1'b0;
            dDone_q <= 1'b0;
            drvCmdValid <= 1'b0;
            drvSel <= 2'b00;
            drvCmd <= 4'h0;
            drvCyl <= {CYL_W{1'b0}};
            multiFn_q <= 1'b0;
        end else begin
            takenDly_q <= pinSync[5];
            doneDly_q <= pinSync[6];
            if (apbWr && selCfg) begin
                multiFn_q <= pwdata[0];
            end
            if (apbWr && selCmd && !pend_q) begin // [R1]
                drvSel <= pwdata[`DCX_DRV_HI:`DCX_DRV_LO]; // [R2]
                drvCmd <= pwdata[`DCX_CMD_HI:`DCX_CMD_LO]; // [R3]
            end
            if (cylWr) begin
                drvCyl <= pwdata[CYL_W-1:0]; // [R8]
                if (!dReady || dBusy || dRsvd) begin
                    pend_q <= 1'b0; // [R7]
                end else begin
                    pend_q <= 1'b1; // [R4] [R8]
                    drvCmdValid <= 1'b1;
                end
            end else if (pend_q && takenRise) begin
                pend_q <= 1'b0; // [R8]
                drvCmdValid <= 1'b0;
            end
            if ((cylWr && (!dReady || dBusy || dRsvd)) || doneRise) begin
                dDone_q <= 1'b1; // [R7] [R9]
            end else if (apbWr && selStat && pwdata[`DCX_ST_DDONE]) begin
                dDone_q <= 1'b0;
            end
        end
    end
    // ----------------------------------------
    // Transfer sequencer
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (srst) begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            xDone_q <= 1'b0;
            tmoErr_q <= 1'b0;
            cylErr_q <= 1'b0;
            srfErr_q <= 1'b0;
            badSec_q <= 1'b0;
            xferCmd <= 4'h0;
            xferSurf <= 5'h00;
            xferSector <= 5'h00;
            secCnt_q <= 5'h00;
            wordCnt_q <= 9'h000;
            dmaAddr <= {ADDR_W{1'b0}};
            dmaReq <= 1'b0;
        end else begin
            if (apbWr && selCmd && !pend_q) begin
                xferCmd <= pwdata[`DCX_CMD_HI:`DCX_CMD_LO]; // [R3]
            end
            if (apbWr && selSsc && !busy_q) begin
                if (multiFn_q) begin
                    xferSurf <= {1'b0, pwdata[`DCX_SRF4_HI:`DCX_SRF_LO]}; // [R12]
                end else begin
                    xferSurf <= pwdata[`DCX_SRF_HI:`DCX_SRF_LO]; // [R12]
                end
                xferSector <= pwdata[`DCX_SEC_HI:`DCX_SEC_LO]; // [R13]
                secCnt_q <= pwdata[`DCX_CNT_HI:`DCX_CNT_LO]; // [R14]
            end
            if (apbWr && selStat) begin
                if (pwdata[`DCX_ST_XDONE]) begin
                    xDone_q <= 1'b0;
                end
            end
            case (state_q)
                ST_IDLE: begin
                    if (startWr) begin
                        dmaAddr <= pwdata[ADDR_W-1:0]; // [R15]
                        busy_q <= 1'b1;
                        xDone_q <= 1'b0;
                        tmoErr_q <= 1'b0;
                        cylErr_q <= 1'b0;
                        srfErr_q <= 1'b0;
                        badSec_q <= 1'b0;
                        state_q <= ST_SEARCH;
                    end
                end
                ST_SEARCH: begin
                    if (!xferEnd && hdrValid && !hdrCrcErr && hdrSector == xferSector) begin
                        if (hdrAlt) begin
                            xferSector <= hdrAltSector; // [R21]
                        end else begin
                            wordCnt_q <= 9'h000;
                            dmaReq <= 1'b1;
                            state_q <= ST_XFER;
                        end
                    end
                end
                ST_XFER: begin
                    if (dmaReq && dmaAck) begin
                        dmaAddr <= dmaAddr + {{(ADDR_W-1){1'b0}}, 1'b1}; // [R23]
                        wordCnt_q <= wordCnt_q + 9'h001;
                        if (wordLast) begin
                            xferSector <= xferSector + 5'h01; // [R22]
                            secCnt_q <= secCnt_q + 5'h01; // [R22]
                            dmaReq <= 1'b0;
                            state_q <= ST_SEARCH;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
            if (xferEnd) begin
                state_q <= ST_IDLE; // [R17]
                busy_q <= 1'b0;
                xDone_q <= 1'b1;
                dmaReq <= 1'b0;
                tmoErr_q <= tmoExpired; // [R18]
                cylErr_q <= endCyl & ~tmoExpired;
                srfErr_q <= endSrf & ~tmoExpired;
                badSec_q <= endBad & ~tmoExpired;
            end
        end
    end
    always @* begin
        xferActive = (state_q != ST_IDLE);
        dmaToMem = (xferCmd == `DCX_CODE_READ);
    end
    assign irq = xDone_q | (dDone_q & ~busy_q); // [R9] [R17]
    // ----------------------------------------
    // APB read data
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (srst) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pslverr <= 1'b0;
            if (psel && !penable) begin
                pslverr <= ~mapped;
                prdata <= 32'h00000000;
                if (pwrite) begin
                    prdata <= 32'h00000000;
                end else if (selStat) begin
                    prdata[`DCX_ST_PEND] <= pend_q; // [R1]
                    prdata[`DCX_ST_BUSY] <= busy_q;
                    prdata[`DCX_ST_XDONE] <= xDone_q;
                    prdata[`DCX_ST_DDONE] <= dDone_q;
                    prdata[`DCX_ST_TMO] <= tmoErr_q;
                    prdata[`DCX_ST_CYLERR] <= cylErr_q;
                    prdata[`DCX_ST_SRFERR] <= srfErr_q;
                    prdata[`DCX_ST_BADSEC] <= badSec_q;
                end else if (selCmd) begin
                    prdata[`DCX_DRV_HI:`DCX_DRV_LO] <= drvSel;
                    prdata[`DCX_CMD_HI:`DCX_CMD_LO] <= drvCmd;
                end else if (selDst) begin
                    prdata[`DCX_DS_READY] <= dReady; // [R6]
                    prdata[`DCX_DS_RSVD] <= dRsvd;
                    prdata[`DCX_DS_FAULT] <= dFault;
                    prdata[`DCX_DS_BUSY] <= dBusy;
                    prdata[`DCX_DS_WPROT] <= dWprot;
                end else if (selCyl) begin
                    prdata[CYL_W-1:0] <= drvCyl;
                end else if (selSsc) begin
                    prdata[`DCX_SRF_HI:`DCX_SRF_LO] <= xferSurf;
                    prdata[`DCX_SEC_HI:`DCX_SEC_LO] <= xferSector;
                    prdata[`DCX_CNT_HI:`DCX_CNT_LO] <= secCnt_q;
                end else if (selAdr) begin
                    prdata[ADDR_W-1:0] <= dmaAddr;
                end else if (selCfg) begin
                    prdata[0] <= multiFn_q;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: dcx_ctrl_asserts.sv
// Concurrent checks on the disk controller top ports.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module dcx_ctrl_asserts #(
    parameter ADDR_W = 16,
    parameter TMO_CYCLES = 2000
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic drvCmdValid,
    input wire logic drvTakenPin,
    input wire logic xferActive,
    input wire logic [3:0] xferCmd,
    input wire logic dmaReq,
    input wire logic dmaToMem,
    input wire logic [ADDR_W-1:0] dmaAddr,
    input wire logic dmaAck,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    wire logic wrCyl = psel && penable && pwrite && paddr == 12'h00c;
    wire logic wrStart = psel && penable && pwrite && paddr == 12'h014;
    logic [31:0] runCnt_q;
    always @(posedge clk_sys) begin
        runCnt_q <= (srst || !xferActive) ? 32'h0 : runCnt_q + 32'h1;
    end
    sequence sWordMove;
        dmaReq && dmaAck;
    endsequence
    sequence sOfferWait;
        drvCmdValid && !drvTakenPin;
    endsequence
    sequence sXferEnd;
        $fell(xferActive) && !$past(srst);
    endsequence
    // ------------------------------------------
    // Properties
    // ------------------------------------------
    chk_offer_cause: assert property ($rose(drvCmdValid) |-> $past(wrCyl))
        else $error("command offer without cylinder write");
    chk_offer_hold: assert property (sOfferWait |=> drvCmdValid)
        else $error("command offer dropped before drive took it");
    chk_start_cause: assert property ($rose(xferActive) |-> $past(wrStart))
        else $error("transfer began without start write");
    chk_addr_step: assert property (sWordMove |=> dmaAddr == ADDR_W'($past(dmaAddr) + 1))
        else $error("dma address did not step by one");
    chk_addr_hold: assert property (!(dmaReq && dmaAck) && !wrStart |=> $stable(dmaAddr))
        else $error("dma address moved without a word");
    chk_busy_mask: assert property (xferActive |-> !irq)
        else $error("interrupt raised while busy");
    chk_end_irq: assert property (sXferEnd |-> irq)
        else $error("transfer ended without interrupt");
    chk_tmo_bound: assert property (runCnt_q <= TMO_CYCLES + 2)
        else $error("transfer outlived its timeout");
    chk_dir_code: assert property (dmaReq |-> dmaToMem == (xferCmd == 4'h0))
        else $error("dma direction does not match command");
endmodule
bind dcx_ctrl dcx_ctrl_asserts #(.ADDR_W(ADDR_W), .TMO_CYCLES(TMO_CYCLES)) uChk (.*);
`default_nettype wire

// File: dcx_disk_model.sv
// Disk drive, header stream and DMA partner for the controller.
// Assumes clk_sys; header fault mode and pace come from the bench.
`timescale 1ns/1ps
`default_nettype none
module dcx_disk_model (
    input wire logic clk_sys,
    input wire logic drvCmdValid,
    input wire logic [9:0] drvCyl,
    input wire logic xferActive,
    input wire logic [4:0] xferSurf,
    input wire logic dmaReq,
    input wire logic [2:0] hdrMode,
    input wire logic slow,
    output logic drvTakenPin,
    output logic drvDonePin,
    output logic hdrValid,
    output logic [9:0] hdrCyl,
    output logic [4:0] hdrSurf,
    output logic [4:0] hdrSector,
    output logic hdrCrcErr,
    output logic hdrBad,
    output logic hdrAlt,
    output logic [4:0] hdrAltSector,
    output logic dmaAck
);
    logic [3:0] take_q = 4'h0;
    logic [3:0] done_q = 4'h0;
    logic [3:0] gap_q = 4'h0;
    logic [4:0] sec_q = 5'h0;
    logic [1:0] wait_q = 2'h0;
    logic retry_q = 1'b0;
    always @(posedge clk_sys) begin
        // Late take, held until offer drops
        take_q <= !drvCmdValid ? 4'h0 : take_q + {3'h0, take_q != 4'hf};
        drvTakenPin <= drvCmdValid && take_q >= (slow ? 4'hc : 4'h2);
        done_q <= (drvTakenPin && !drvCmdValid) ? 4'hc : done_q - {3'h0, done_q != 4'h0};
        drvDonePin <= done_q != 4'h0 && done_q < 4'h5;
        // Headers every eight cycles while searching, none in header mode 6
        gap_q <= gap_q + 4'h1;
        hdrValid <= xferActive && !dmaReq && gap_q[2:0] == 3'h0 && hdrMode != 3'h6;
        sec_q <= sec_q + {4'h0, hdrValid};
        retry_q <= xferActive && (retry_q || (hdrValid && hdrCrcErr));
        // One word per request, slow pace waits between words
        wait_q <= (dmaReq && !dmaAck) ? wait_q + 2'h1 : 2'h0;
        dmaAck <= dmaReq && !dmaAck && (!slow || wait_q == 2'h3);
    end
    // Idle header lines show noise
    assign hdrCyl = hdrValid ? drvCyl ^ {9'h0, hdrMode == 3'h2} : ~drvCyl;
    assign hdrSurf = hdrValid ? xferSurf ^ {4'h0, hdrMode == 3'h3} : ~xferSurf;
    assign hdrSector = hdrValid ? sec_q : ~sec_q;
    assign hdrCrcErr = hdrValid ? hdrMode == 3'h1 && sec_q == 5'h03 && !retry_q : gap_q[0];
    assign hdrBad = hdrValid ? hdrMode == 3'h4 : gap_q[0];
    assign hdrAlt = hdrValid ? hdrMode == 3'h5 && sec_q == 5'h03 : gap_q[0];
    assign hdrAltSector = hdrValid ? 5'h09 : ~sec_q;
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the disk command and transfer controller.
// Assumes the design files and the disk partner model compile first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic drvReadyPin = 1'b1;
    logic drvReservedPin = 1'b0, drvFaultPin = 1'b0, drvBusyPin = 1'b0, drvWriteProtPin = 1'b0;
    logic [2:0] hdrMode = 3'h0;
    logic slow = 1'b1;
    logic pready, pslverr, drvCmdValid, drvTakenPin, drvDonePin, hdrValid, hdrCrcErr;
    logic hdrBad, hdrAlt, xferActive, dmaReq, dmaToMem, dmaAck, irq, err;
    logic [1:0] drvSel;
    logic [3:0] drvCmd, xferCmd;
    logic [9:0] drvCyl, hdrCyl;
    logic [4:0] hdrSurf, hdrSector, hdrAltSector, xferSurf, xferSector;
    logic [15:0] dmaAddr;
    logic [31:0] prdata, rd;
    int num_errors = 0;
    int compares = 0;
    always #5 clk_sys = ~clk_sys;
    dcx_ctrl #(.WORDS(4), .TMO_CYCLES(2000)) uut (
        .clk_sys, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .drvReadyPin, .drvReservedPin, .drvFaultPin, .drvBusyPin, .drvWriteProtPin, .drvTakenPin,
        .drvDonePin, .drvCmdValid, .drvSel, .drvCmd, .drvCyl, .hdrValid, .hdrCyl, .hdrSurf,
        .hdrSector, .hdrCrcErr, .hdrBad, .hdrAlt, .hdrAltSector, .xferActive, .xferCmd,
        .xferSurf, .xferSector, .dmaReq, .dmaToMem, .dmaAddr, .dmaAck, .irq
    );
    dcx_disk_model uDisk (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic poll(input int b, input logic v);
        do apb(1'b0, 12'h000, 32'h0); while (rd[b] !== v);
    endtask
    task automatic t_drive;
        apb(1'b0, 12'h01c, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
        for (int c = 1; c <= 4; c++) begin
            apb(1'b1, 12'h004, {21'h0, c[3:0], 2'h2, 5'h0});
            apb(1'b1, 12'h00c, 32'h100 + c);
            apb(1'b0, 12'h000, 32'h0);
            chk(rd[15], 1'b1);
            chk({drvCmdValid, drvSel, drvCmd, drvCyl}, {1'b1, 2'h2, c[3:0], 10'h100 + c[9:0]});
            apb(1'b1, 12'h004, 32'h0);
            apb(1'b0, 12'h004, 32'h0);
            chk(rd[10:5], {c[3:0], 2'h2});
            poll(15, 1'b0);
            poll(12, 1'b1);
            chk(irq, 1'b1);
            apb(1'b1, 12'h000, 32'h1000);
        end
    endtask
    task automatic t_reject;
        for (int k = 0; k < 4; k++) begin
            drvReadyPin <= k != 0;
            drvReservedPin <= k == 1;
            drvBusyPin <= k == 2;
            drvFaultPin <= k == 0;
            drvWriteProtPin <= k == 1;
            repeat (4) @(posedge clk_sys);
            apb(1'b0, 12'h008, 32'h0);
            chk(rd[15:11], {k != 0, k == 1, k == 0, k == 2, k == 1});
            if (k < 3) begin
                apb(1'b1, 12'h00c, 32'h3ff);
                apb(1'b0, 12'h000, 32'h0);
                chk({rd[15], rd[12], drvCmdValid}, 3'b010);
                apb(1'b1, 12'h000, 32'h1000);
            end
        end
    endtask
    task automatic xfer(input logic [3:0] code, input logic mf, input logic [2:0] mode,
        input logic [4:0] cnt, input logic [7:0] st, input logic [4:0] sec, input logic [15:0] adr);
        hdrMode <= mode;
        apb(1'b0, 12'h008, 32'h0);
        chk(rd[15:11] & 5'b10101, 5'b10000);
        poll(14, 1'b0);
        apb(1'b1, 12'h018, {31'h0, mf});
        apb(1'b1, 12'h004, {21'h0, code, 2'h1, 5'h0});
        apb(1'b1, 12'h010, {17'h0, 5'h13, 5'h03, cnt});
        apb(1'b0, 12'h010, 32'h0);
        chk(rd[9:0], {5'h03, cnt});
        apb(1'b1, 12'h014, 32'h100);
        chk({xferCmd, xferSurf}, {code, mf ? 5'h03 : 5'h13});
        poll(14, 1'b0);
        chk(rd[15:8] & 8'hef, st);
        chk({irq, xferSector, dmaAddr}, {1'b1, sec, adr});
        apb(1'b1, 12'h000, 32'h3000);
    endtask
    task automatic wrap_up;
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #600000;
        num_errors++;
        wrap_up;
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        t_drive;
        t_reject;
        apb(1'b1, 12'h004, {21'h0, 4'h2, 2'h1, 5'h0});
        apb(1'b1, 12'h00c, 32'h155);
        poll(15, 1'b0);
        xfer(4'h0, 1'b0, 3'h0, 5'h1e, 8'h20, 5'h05, 16'h108);
        xfer(4'he, 1'b1, 3'h1, 5'h1f, 8'h20, 5'h04, 16'h104);
        slow <= 1'b0;
        xfer(4'hc, 1'b0, 3'h5, 5'h1f, 8'h20, 5'h0a, 16'h104);
        xfer(4'h0, 1'b0, 3'h2, 5'h1f, 8'h24, 5'h03, 16'h100);
        xfer(4'h0, 1'b0, 3'h3, 5'h1f, 8'h22, 5'h03, 16'h100);
        xfer(4'h0, 1'b0, 3'h4, 5'h1f, 8'h21, 5'h03, 16'h100);
        xfer(4'h0, 1'b0, 3'h6, 5'h1f, 8'h28, 5'h03, 16'h100);
        wrap_up;
    end
endmodule
`default_nettype wire
